// ---- logic/dcm_top.sv ----
// Purpose: Debug comms channel between core (APB) and debugger (scan), plus monitor-mode control
// Assumes: tck, tdi, scan_sel come from outside and are oversampled by clk (tck much slower)
// Notes:   APB answers with one wait state; scan frame aborts when scan_sel drops
// Operation
// (RULE_01) Core reads outbound-full before writing the outbound data register.
// (RULE_02) Core polls status while outbound-full is set, no new outbound write.
// (RULE_03) Core write of outbound data sets outbound-full.
// (RULE_04) Debugger status poll over scan returns inbound-full and outbound-full.
// (RULE_05) Debugger scan read of outbound data clears outbound-full.
// (RULE_06) Debugger polls inbound-full and writes inbound data only when clear.
// (RULE_07) Debugger scan write of inbound data sets inbound-full.
// (RULE_08) Core reads inbound data only after seeing inbound-full set.
// (RULE_09) Core read of inbound data clears inbound-full.
// (RULE_10) Control bit 4 selects monitor-mode debugging instead of halting.
// (RULE_11) Monitor mode: breakpoint gives prefetch abort, watchpoint gives data abort.
// (RULE_12) Monitor mode comparisons ignore data values, no range or chaining.
// (RULE_13) Match terms: address, watch conditioner, privilege, read/write, access size.
// (RULE_14) Monitor mode disables single-step and ignores external breakpoints.
// (RULE_15) Vector catch must not target prefetch or data abort in monitor mode.
// (RULE_16) Debug requests must not be raised while monitor mode is on.
// (RULE_17) Monitor-mode aborts are recorded in the abort status register.
// (RULE_18) Monitor mode never halts the core; watch registers change live.
// (RULE_19) Software sets bit 5 to disable watch unit while reprogramming.
// (RULE_20) Status bit 0 is inbound-full.
// (RULE_21) Status bit 1 is outbound-full.
// (RULE_22) Status top nibble is a fixed version code, middle bits zero.
// (RULE_23) Both full flags are zero after reset.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module dcm_top #(
  parameter logic [3:0] VERSION = 4'h3  // Arbitrary value
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [4:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [31:0]             prdata,
  // Debugger scan pins
  input  wire logic               tck,
  input  wire logic               tdi,
  input  wire logic               scan_sel,
  output logic                    tdo,
  // Core watch inputs
  input  wire dcm_pkg::dcm_fetch_t fetch,
  input  wire dcm_pkg::dcm_dacc_t  dacc,
  input  wire logic               external_watch_conditioner,
  input  wire logic               ext_breakpoint,
  input  wire logic               external_debug_request,
  // Core debug outputs
  output logic                    prefetch_abort,
  output logic                    data_abort,
  output logic                    debug_entry,
  output logic                    step_enable
);
  if (VERSION == 4'h0) begin : g_chk
    $error("VERSION must be nonzero");
  end

  dcm_pkg::dcm_state_t s, n;
  logic        apb_done;
  logic        rd_data;
  logic        tck_rise;
  logic        tck_fall;
  logic [2:0]  hdr_full;
  logic [31:0] scan_word;
  logic        sc_commit;
  logic        sc_wr_in;
  logic        sc_rd_out;
  logic        mon;
  logic        bp_hit;
  logic        wp_hit;
  logic [31:0] status;

  assign apb_done  = psel & penable & s.pready;
  assign rd_data   = apb_done & ~pwrite & (paddr == dcm_pkg::OFS_DATA);
  assign tck_rise  = s.tck_s2 & ~s.tck_p;
  assign tck_fall  = s.tck_p & ~s.tck_s2;
  assign hdr_full  = {s.tdi_s2, s.hdr[2:1]};
  assign scan_word = {s.tdi_s2, s.sh[31:1]};
  assign sc_commit = tck_rise & s.sel_s2 & (s.cnt == dcm_pkg::DATA_LAST);
  assign sc_wr_in  = sc_commit & s.hdr[0] & (s.hdr[2:1] == dcm_pkg::SC_IN);
  assign sc_rd_out = sc_commit & ~s.hdr[0] & (s.hdr[2:1] == dcm_pkg::SC_OUT);
  // (RULE_10) monitor select
  assign mon       = s.ctrl[dcm_pkg::CTL_MON];
  // (RULE_20) (RULE_21) (RULE_22) status layout
  assign status    = {VERSION, 26'h0, s.w, s.r};

  // (RULE_12) (RULE_13) exact address, no data terms
  assign bp_hit = fetch.valid & s.mctl.bp_en & ~s.ctrl[dcm_pkg::CTL_WDIS]
                & (fetch.addr == s.bp_addr)
                & (~s.mctl.bp_priv_care | (fetch.priv == s.mctl.bp_priv_val))
                & (~s.mctl.bp_size_care | (fetch.size == s.mctl.bp_size));
  assign wp_hit = dacc.valid & s.mctl.wp_en & ~s.ctrl[dcm_pkg::CTL_WDIS]
                & (dacc.addr == s.wp_addr)
                & (~s.mctl.wp_priv_care | (dacc.priv == s.mctl.wp_priv_val))
                & (~s.mctl.wp_rw_care | (dacc.write == s.mctl.wp_rw_val))
                & (~s.mctl.wp_ext_care | (external_watch_conditioner == s.mctl.wp_ext_val));

  always_comb begin
    n = s;
    // APB: one wait state, read data captured with pready
    n.pready  = psel & penable & ~s.pready;
    n.pslverr = 1'b0;
    if (psel & penable & ~s.pready) begin
      unique case (paddr)
        dcm_pkg::OFS_STATUS: n.prdata = status;
        dcm_pkg::OFS_DATA:   n.prdata = s.din;
        dcm_pkg::OFS_CTRL:   n.prdata = s.ctrl;
        dcm_pkg::OFS_ABORT:  n.prdata = {30'h0, s.abt};
        dcm_pkg::OFS_BPADDR: n.prdata = s.bp_addr;
        dcm_pkg::OFS_WPADDR: n.prdata = s.wp_addr;
        dcm_pkg::OFS_MATCH:  n.prdata = s.mctl;
        default: begin
          n.prdata  = 32'h0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    // Clears first, hardware sets below win in the same cycle
    // (RULE_09) core read empties inbound
    if (rd_data) begin
      n.r = 1'b0;
    end
    if (apb_done & pwrite) begin
      unique case (paddr)
        dcm_pkg::OFS_DATA: begin
          // (RULE_03) outbound word loaded
          n.dout = pwdata;
          n.w    = 1'b1;
        end
        dcm_pkg::OFS_CTRL:   n.ctrl = pwdata & dcm_pkg::CTL_MASK;
        dcm_pkg::OFS_ABORT:  n.abt  = s.abt & ~pwdata[1:0];
        dcm_pkg::OFS_BPADDR: n.bp_addr = pwdata;
        dcm_pkg::OFS_WPADDR: n.wp_addr = pwdata;
        dcm_pkg::OFS_MATCH:  n.mctl = {19'h0, pwdata[12:0]};
        default: ;
      endcase
    end
    // Scan pins: second flop is the only reader of the first
    n.tck_s1 = tck;
    n.tck_s2 = s.tck_s1;
    n.tck_p  = s.tck_s2;
    n.tdi_s1 = tdi;
    n.tdi_s2 = s.tdi_s1;
    n.sel_s1 = scan_sel;
    n.sel_s2 = s.sel_s1;
    if (~s.sel_s2) begin
      n.cnt = 6'h0;
    end else if (tck_rise && s.cnt != dcm_pkg::CNT_DONE) begin
      n.cnt = s.cnt + 6'h1;
      if (s.cnt <= dcm_pkg::HDR_LAST) begin
        n.hdr = hdr_full;
      end else begin
        n.sh = scan_word;
      end
      if (s.cnt == dcm_pkg::HDR_LAST) begin
        // (RULE_04) status frame carries both flags
        unique case (hdr_full[2:1])
          dcm_pkg::SC_STATUS: n.sh = status;
          dcm_pkg::SC_OUT:    n.sh = s.dout;
          default:            n.sh = 32'h0;
        endcase
      end
    end
    if (s.sel_s2 & tck_fall) begin
      n.tdo = s.sh[0];
    end
    // (RULE_05) full word shifted out
    if (sc_rd_out & ~(apb_done & pwrite & (paddr == dcm_pkg::OFS_DATA))) begin
      n.w = 1'b0;
    end
    // (RULE_07) debugger deposit
    if (sc_wr_in) begin
      n.din = scan_word;
      n.r   = 1'b1;
    end
    // (RULE_11) (RULE_18) monitor aborts instead of halting
    n.pabt      = mon & bp_hit;
    n.dabt      = mon & wp_hit;
    // (RULE_14) external sources only honoured when halting
    n.dbg_entry = ~mon & (bp_hit | wp_hit | ext_breakpoint | external_debug_request
                          | s.ctrl[dcm_pkg::CTL_IREQ]);
    n.step_en   = ~mon & s.ctrl[dcm_pkg::CTL_STEP];
    // (RULE_17) sticky record, set wins over clear
    if (mon & bp_hit) begin
      n.abt[dcm_pkg::AB_PABT] = 1'b1;
    end
    if (mon & wp_hit) begin
      n.abt[dcm_pkg::AB_DABT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // (RULE_23) flags start clear
      s      <= '0;
      s.ctrl <= dcm_pkg::CTL_RST;
    end else begin
      s <= n;
    end
  end

  assign pready         = s.pready;
  assign pslverr        = s.pslverr;
  assign prdata         = s.prdata;
  assign tdo            = s.tdo;
  assign prefetch_abort = s.pabt;
  assign data_abort     = s.dabt;
  assign debug_entry    = s.dbg_entry;
  assign step_enable    = s.step_en;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_wfull_set: assert property ( // RULE_03
    apb_done && pwrite && paddr == dcm_pkg::OFS_DATA |=> s.w && s.dout == $past(pwdata))
    else $error("outbound-full not set by core write");
  a_scan_status: assert property ( // RULE_04
    tck_rise && s.sel_s2 && s.cnt == dcm_pkg::HDR_LAST && hdr_full[2:1] == dcm_pkg::SC_STATUS
    |=> s.sh[1:0] == {$past(s.w), $past(s.r)} && s.sh[31:28] == VERSION)
    else $error("scan status lacks flags");
  a_wfull_clear: assert property ( // RULE_05
    sc_rd_out && !(apb_done && pwrite) |=> !s.w)
    else $error("outbound-full not cleared by scan read");
  a_rfull_set: assert property ( // RULE_07
    sc_wr_in |=> s.r && s.din == $past(scan_word))
    else $error("inbound-full not set by scan write");
  a_rfull_clear: assert property ( // RULE_09
    rd_data && !sc_wr_in |=> !s.r)
    else $error("inbound-full not cleared by core read");
  a_mon_pabt: assert property ( // RULE_11
    mon && bp_hit |=> prefetch_abort && !debug_entry)
    else $error("breakpoint in monitor mode gave no prefetch abort");
  a_mon_dabt: assert property ( // RULE_11
    mon && wp_hit |=> data_abort && !debug_entry)
    else $error("watchpoint in monitor mode gave no data abort");
  a_mon_nohalt: assert property ( // RULE_14
    mon |=> !debug_entry && !step_enable)
    else $error("monitor mode halted or stepped");
  a_abort_record: assert property ( // RULE_17
    prefetch_abort |-> s.abt[dcm_pkg::AB_PABT])
    else $error("monitor abort not recorded");
  a_status_read: assert property ( // RULE_21
    apb_done && !pwrite && paddr == dcm_pkg::OFS_STATUS
    |-> prdata == {VERSION, 26'h0, $past(s.w), $past(s.r)})
    else $error("status read wrong");
  a_wdis_quiet: assert property ( // RULE_19
    s.ctrl[dcm_pkg::CTL_WDIS] |=> !prefetch_abort && !data_abort)
    else $error("match while watch unit disabled");

  // Flags clear after reset and hold until the far side acts on them; scan read loads outbound word
  a_reset_flags: assert property ( // RULE_23
    $rose(arst_n) |-> !s.w && !s.r)
    else $error("full flag set after reset");
  a_rfull_hold: assert property ( // RULE_20
    s.r && !rd_data |=> s.r)
    else $error("inbound-full dropped without core read");
  a_wfull_hold: assert property ( // RULE_21
    s.w && !sc_rd_out |=> s.w)
    else $error("outbound-full dropped without scan read");
  a_scan_out: assert property ( // RULE_05
    tck_rise && s.sel_s2 && s.cnt == dcm_pkg::HDR_LAST && hdr_full[2:1] == dcm_pkg::SC_OUT
    |=> s.sh == $past(s.dout))
    else $error("scan read did not load outbound word");

  // Halting path is live only while monitor mode is off
  a_halt_entry: assert property ( // RULE_10
    !mon && (bp_hit || wp_hit) |=> debug_entry && !prefetch_abort && !data_abort)
    else $error("halting match gave no debug entry");
  a_halt_noabort: assert property ( // RULE_11
    !mon |=> !prefetch_abort && !data_abort)
    else $error("abort raised outside monitor mode");
  a_ext_request: assert property ( // RULE_14
    !mon && external_debug_request |=> debug_entry)
    else $error("external request ignored while halting");
  a_step_level: assert property ( // RULE_14
    !mon && s.ctrl[dcm_pkg::CTL_STEP] |=> step_enable)
    else $error("single-step not enabled while halting");

  // Match qualifiers and abort record
  a_wp_cond: assert property ( // RULE_13
    mon && dacc.valid && s.mctl.wp_ext_care
    && external_watch_conditioner != s.mctl.wp_ext_val |=> !data_abort)
    else $error("watchpoint ignored its conditioner");
  a_bp_priv: assert property ( // RULE_13
    mon && fetch.valid && s.mctl.bp_priv_care && fetch.priv != s.mctl.bp_priv_val
    |=> !prefetch_abort)
    else $error("breakpoint ignored its privilege term");
  a_dabt_record: assert property ( // RULE_17
    data_abort |-> s.abt[dcm_pkg::AB_DABT])
    else $error("data abort not recorded");

  c_scan_write: cover property (sc_wr_in ##[1:200] rd_data);
  c_scan_read: cover property (apb_done && pwrite && paddr == dcm_pkg::OFS_DATA ##[1:900] sc_rd_out);
  c_mon_abort: cover property (mon && bp_hit ##1 prefetch_abort);
  c_ext_request: cover property (!mon && external_debug_request ##1 debug_entry);
  c_wp_cond: cover property (mon && wp_hit && s.mctl.wp_ext_care ##1 data_abort);
endmodule : dcm_top

// ---- logic/dcm_pkg.sv ----
// Purpose: Shared constants and carriers for the debug comms channel and monitor control
// Assumes: 32-bit APB, word-aligned registers
// Notes:   Scan frame is 3 header bits then 32 data bits, LSB first
package dcm_pkg;
  // APB byte offsets
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_DATA   = 5'h04;
  localparam logic [4:0] OFS_CTRL   = 5'h08;
  localparam logic [4:0] OFS_ABORT  = 5'h0c;
  localparam logic [4:0] OFS_BPADDR = 5'h10;
  localparam logic [4:0] OFS_WPADDR = 5'h14;
  localparam logic [4:0] OFS_MATCH  = 5'h18;
  // Status fields
  localparam int unsigned ST_RFULL = 0;
  localparam int unsigned ST_WFULL = 1;
  localparam int unsigned ST_VER   = 28;
  // Debug control fields
  localparam int unsigned CTL_IREQ = 1;
  localparam int unsigned CTL_STEP = 2;
  localparam int unsigned CTL_MON  = 4;
  localparam int unsigned CTL_WDIS = 5;
  localparam logic [31:0] CTL_MASK = 32'h0000_0036;
  localparam logic [31:0] CTL_RST  = 32'h0000_0000;
  // Abort status fields
  localparam int unsigned AB_PABT = 0;
  localparam int unsigned AB_DABT = 1;
  // Scan frame
  localparam logic [1:0] SC_STATUS = 2'h0;
  localparam logic [1:0] SC_OUT    = 2'h1;
  localparam logic [1:0] SC_IN     = 2'h2;
  localparam logic [5:0] HDR_LAST  = 6'h02;
  localparam logic [5:0] DATA_LAST = 6'h22;
  localparam logic [5:0] CNT_DONE  = 6'h23;

  typedef struct packed {
    logic [18:0] rsvd;
    logic        wp_ext_val;
    logic        wp_ext_care;
    logic        wp_rw_val;
    logic        wp_rw_care;
    logic        wp_priv_val;
    logic        wp_priv_care;
    logic        wp_en;
    logic [1:0]  bp_size;
    logic        bp_size_care;
    logic        bp_priv_val;
    logic        bp_priv_care;
    logic        bp_en;
  } dcm_match_t;

  typedef struct packed {
    logic        valid;
    logic        priv;
    logic [1:0]  size;
    logic [31:0] addr;
  } dcm_fetch_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        priv;
    logic [31:0] addr;
  } dcm_dacc_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        r;
    logic        w;
    logic [31:0] din;
    logic [31:0] dout;
    logic [31:0] ctrl;
    logic [1:0]  abt;
    logic [31:0] bp_addr;
    logic [31:0] wp_addr;
    dcm_match_t  mctl;
    logic        tck_s1;
    logic        tck_s2;
    logic        tck_p;
    logic        tdi_s1;
    logic        tdi_s2;
    logic        sel_s1;
    logic        sel_s2;
    logic [5:0]  cnt;
    logic [2:0]  hdr;
    logic [31:0] sh;
    logic        tdo;
    logic        pabt;
    logic        dabt;
    logic        dbg_entry;
    logic        step_en;
  } dcm_state_t;
endpackage : dcm_pkg

// ---- verification/dcm_dbg_model.sv ----
// Purpose: Behavioural debugger driving the scan pins of the comms channel
// Assumes: tck period 8 clk (320 ns), standing still outside frames
// Notes:   Frame is write flag, two address bits, 32 data bits, LSB first
`timescale 1ns/1ps
module dcm_dbg_model (
  // Clock
  input  wire logic clk,
  // Scan pins
  output logic      tck,
  output logic      tdi,
  output logic      scan_sel,
  input  wire logic tdo
);
  initial begin
    tck      = 1'b0;
    tdi      = 1'b0;
    scan_sel = 1'b0;
  end
  // One whole frame; tdo is taken late in the high phase, before the next fall
  task automatic frame(input logic w, input logic [1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    logic [34:0] bits;
    bits = {d, a, w};
    q = '0;
    scan_sel <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 35; i++) begin
      tdi <= bits[i];
      repeat (4) @(posedge clk);
      tck <= 1'b1;
      repeat (4) @(posedge clk);
      if (i > 2) q[i-3] = tdo;
      tck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    // Released data line shows the inverse of its last bit
    scan_sel <= 1'b0;
    tdi      <= ~bits[34];
    repeat (12) @(posedge clk);
  endtask : frame
endmodule : dcm_dbg_model

// ---- verification/dcm_top_tb_top.sv ----
// Purpose: Self-checking bench for the comms channel and monitor-mode control
// Assumes: APB master here, scan debugger in its own model
// Notes:   Expected APB answers wait in a queue until pready shows up
`timescale 1ns/1ps
module dcm_top_tb_top;
  localparam logic [3:0] VER = 4'ha;  // Arbitrary value
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [4:0]  paddr;
  logic [31:0] pwdata, prdata, w0, q0;
  logic        tck, tdi, scan_sel, tdo, ext_bp, pa, da, de, se, ewc, edr;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  dcm_pkg::dcm_fetch_t fetch;
  dcm_pkg::dcm_dacc_t  dacc;
  integer      n_pa = 0, n_da = 0, n_de = 0;
  int          n_fail = 0, check_count = 0;

  dcm_top #(.VERSION(VER)) u_dcm_top (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .tck(tck), .tdi(tdi), .scan_sel(scan_sel), .tdo(tdo), .fetch(fetch), .dacc(dacc),
    .external_watch_conditioner(ewc), .ext_breakpoint(ext_bp),
    .external_debug_request(edr), .prefetch_abort(pa), .data_abort(da),
    .debug_entry(de), .step_enable(se));
  dcm_dbg_model u_dcm_dbg_model (.clk(clk), .tck(tck), .tdi(tdi), .scan_sel(scan_sel),
    .tdo(tdo));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // Pulses are counted so a stuck or doubled pulse shows in the totals
  // Gated by reset so an unknown before the first reset edge cannot poison the totals
  always @(posedge clk) begin
    if (arst_n) begin
      n_pa <= n_pa + pa;
      n_da <= n_da + da;
      n_de <= n_de + de;
    end
  end

  // Write answers check only the error flag; their read data is undefined
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(33'h0, 33'h1);
      end else begin
        e = exp_q.pop_front();
        if (e[33]) check({pslverr, prdata}, e[32:0]);
        else check({pslverr, 32'h0}, {e[32], 32'h0});
      end
    end
  end

  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    int i;
    i = 0;
    exp_q.push_back({~w, x});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 40) begin
      n_fail++;
      summarize();
    end else @(posedge clk);
  endtask : apb

  function automatic logic [32:0] st(input logic w, input logic r);
    return {1'b0, VER, 26'h0, w, r};
  endfunction : st

  task automatic hit(input logic [31:0] ia, input logic [31:0] dv, input logic xb);
    fetch <= {1'b1, 1'b1, 2'h2, ia};
    @(posedge clk);
    fetch <= '0;
    dacc  <= {1'b1, 1'b1, 1'b1, dv};
    @(posedge clk);
    dacc   <= '0;
    ext_bp <= xb;
    @(posedge clk);
    ext_bp <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : hit

  task automatic cnt(input logic [7:0] p, input logic [7:0] d, input logic [7:0] g);
    check({n_pa[7:0], n_da[7:0], n_de[7:0]}, {p, d, g});
  endtask : cnt

  initial begin
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, ext_bp, ewc, edr} = '0;
    fetch = '0;
    dacc  = '0;
    void'($urandom(32'hcef2));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(0, dcm_pkg::OFS_STATUS, 32'h0, st(0, 0));
    apb(1, dcm_pkg::OFS_STATUS, 32'hffff_ffff, 33'h0);
    apb(0, dcm_pkg::OFS_STATUS, 32'h0, st(0, 0));
    w0 = $urandom();
    apb(1, dcm_pkg::OFS_DATA, w0, 33'h0);
    apb(0, dcm_pkg::OFS_STATUS, 32'h0, st(1, 0));
    u_dcm_dbg_model.frame(0, dcm_pkg::SC_STATUS, $urandom(), q0);
    check({1'b0, q0}, st(1, 0));
    u_dcm_dbg_model.frame(0, dcm_pkg::SC_OUT, $urandom(), q0);
    check({1'b0, q0}, {1'b0, w0});
    apb(0, dcm_pkg::OFS_STATUS, 32'h0, st(0, 0));
    w0 = $urandom();
    u_dcm_dbg_model.frame(1, dcm_pkg::SC_IN, w0, q0);
    u_dcm_dbg_model.frame(0, dcm_pkg::SC_STATUS, $urandom(), q0);
    check({1'b0, q0}, st(0, 1));
    apb(0, dcm_pkg::OFS_STATUS, 32'h0, st(0, 1));
    apb(0, dcm_pkg::OFS_DATA, 32'h0, {1'b0, w0});
    apb(0, dcm_pkg::OFS_STATUS, 32'h0, st(0, 0));
    apb(0, 5'h1c, 32'h0, {1'b1, 32'h0});
    w0 = $urandom() & 32'hffff_fffd;
    apb(1, dcm_pkg::OFS_CTRL, w0, 33'h0);
    apb(0, dcm_pkg::OFS_CTRL, 32'h0, {1'b0, w0 & dcm_pkg::CTL_MASK});
    apb(1, dcm_pkg::OFS_CTRL, 32'h24, 33'h0);
    repeat (2) @(posedge clk);
    check(se, 1);
    apb(1, dcm_pkg::OFS_BPADDR, w0, 33'h0);
    apb(1, dcm_pkg::OFS_WPADDR, ~w0, 33'h0);
    apb(1, dcm_pkg::OFS_MATCH, 32'h41, 33'h0);
    apb(1, dcm_pkg::OFS_CTRL, 32'h14, 33'h0);
    repeat (2) @(posedge clk);
    check(se, 0);
    hit(w0, ~w0, 1);
    cnt(1, 1, 0);
    apb(0, dcm_pkg::OFS_ABORT, 32'h0, {1'b0, 32'h3});
    apb(1, dcm_pkg::OFS_CTRL, 32'h34, 33'h0);
    hit(w0, ~w0, 0);
    cnt(1, 1, 0);
    apb(1, dcm_pkg::OFS_ABORT, 32'h3, 33'h0);
    apb(1, dcm_pkg::OFS_CTRL, 32'h0, 33'h0);
    hit(w0, ~w0, 1);
    cnt(1, 1, 3);
    apb(0, dcm_pkg::OFS_ABORT, 32'h0, 33'h0);
    edr <= 1'b1;
    @(posedge clk);
    edr <= 1'b0;
    repeat (3) @(posedge clk);
    cnt(1, 1, 4);
    apb(1, dcm_pkg::OFS_CTRL, 32'h20, 33'h0);
    apb(1, dcm_pkg::OFS_MATCH, 32'h1843, 33'h0);
    apb(1, dcm_pkg::OFS_CTRL, 32'h10, 33'h0);
    hit(w0, ~w0, 0);
    cnt(1, 1, 4);
    ewc <= 1'b1;
    hit(w0, ~w0, 0);
    ewc <= 1'b0;
    cnt(1, 2, 4);
    apb(0, dcm_pkg::OFS_ABORT, 32'h0, {1'b0, 32'h2});
    summarize();
  end
endmodule : dcm_top_tb_top
